//--- mii_mgmt_pkg.sv
// shared constants and carrier types for the management slave and phy master
// assumes a single 20 MHz system clock for all logic
package mii_mgmt_pkg;

    // timing
    localparam int CLK_PERIOD_NS   = 50;
    localparam int MDC_PERIOD_NS   = 400;
    localparam int MDC_DIV         = MDC_PERIOD_NS / CLK_PERIOD_NS;
    localparam int OUT_DELAY_NS    = 120;
    localparam int OUT_DELAY_CYC   = (OUT_DELAY_NS / CLK_PERIOD_NS < 1) ? 1 : OUT_DELAY_NS / CLK_PERIOD_NS;
    localparam int SAMPLE_LEAD_NS  = 40;
    localparam int SAMPLE_LEAD_CYC = (SAMPLE_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // register byte offsets
    localparam logic [9:0] OFS_PHY_DATA   = 10'h0A4;
    localparam logic [9:0] OFS_PHY_ACCESS = 10'h0A8;
    localparam logic [9:0] OFS_BYTE_TEST  = 10'h064;
    localparam logic [9:0] OFS_HARDWARE_CONFIG_REG     = 10'h074;
    localparam logic [9:0] OFS_POWER_MGMT_CONTROL_REG   = 10'h084;
    localparam logic [9:0] OFS_RESET_CONTROL_REG  = 10'h1F8;

    // access register fields and the hardware config ready bit
    localparam int ACC_PHY_LSB  = 11;
    localparam int ACC_IDX_LSB  = 6;
    localparam int ACC_WSEL_BIT = 1;
    localparam int ACC_BUSY_BIT = 0;
    localparam int HWCFG_READY_BIT = 27;

    // reset values and patterns
    localparam logic [15:0] PHY_DATA_RST      = 16'h0000;
    localparam logic [31:0] BYTE_TEST_PATTERN = 32'h5A3CC3A5;

    // frame fields
    localparam logic [5:0] PREAMBLE_LEN = 6'h20;
    localparam logic [1:0] FRM_START    = 2'h1;
    localparam logic [1:0] OP_READ      = 2'h2;
    localparam logic [1:0] OP_WRITE     = 2'h1;
    localparam logic [1:0] TA_WRITE     = 2'h2;
    localparam logic [5:0] HDR_BITS     = 6'h0C;
    localparam logic [6:0] FRAME_BITS   = 7'h40;
    localparam logic [6:0] TA_FIRST_BIT = 7'h2E;
    localparam logic [6:0] DATA_FIRST   = 7'h31;

    typedef struct packed {
        logic        start;
        logic        write;
        logic [4:0]  target_device_number;
        logic [4:0]  reg_idx;
        logic [15:0] wdata;
    } phy_cmd_type;

    typedef struct packed {
        logic        done;
        logic [15:0] rdata;
    } phy_rsp_type;

    typedef struct packed {
        logic clk;
        logic dout;
        logic oe;
    } mgmt_pins_type;

    typedef struct packed {
        logic        valid;
        logic [9:0]  addr;
        logic [31:0] data;
    } loader_wr_type;

endpackage

//--- phy_mgmt_master.sv
// serialiser that runs management frames to the phys on its own divided clock
// assumes commands arrive only while idle and the data line has a pull-up
`timescale 1ns/1ns
`default_nettype none
module phy_mgmt_master import mii_mgmt_pkg::*; (
    input  wire logic          ref_clk,
    input  wire logic          rstn,
    input  wire phy_cmd_type   cmd,
    input  wire logic          mdio_in,
    output var  phy_rsp_type   rsp,
    output var  mgmt_pins_type pins
);
    localparam logic [2:0] LAST_PHASE = 3'(MDC_DIV - 1);
    localparam logic [2:0] HALF_PHASE = 3'(MDC_DIV / 2);
    localparam logic [2:0] CHG_PHASE  = 3'(OUT_DELAY_CYC - 1);
    localparam logic [2:0] SMP_PHASE  = 3'(SAMPLE_LEAD_CYC);

    typedef enum logic {M_IDLE, M_RUN} mst_state_type;

    typedef struct packed {
        mst_state_type state;
        logic [2:0]    phase;
        logic          mdc;
        logic          dout;
        logic          oe;
        logic [6:0]    bit_cnt;
        logic [63:0]   shift;
        logic          write;
        logic [15:0]   rdata;
        logic          done;
        logic [1:0]    din_s;
    } mst_st_type;

    mst_st_type st_r;
    mst_st_type st_nxt;

    always_comb begin
        logic [2:0] ph;
        ph = (st_r.phase == LAST_PHASE) ? 3'h0 : st_r.phase + 3'h1;
        st_nxt = st_r;
        st_nxt.phase = ph;
        st_nxt.mdc = (ph < HALF_PHASE);                    // [RQ11] [RQ24]
        st_nxt.din_s = {st_r.din_s[0], mdio_in};
        st_nxt.done = 1'h0;
        case (st_r.state)
            M_IDLE: begin
                st_nxt.oe = 1'h0;                          // [RQ15]
                if (cmd.start) begin
                    st_nxt.state = M_RUN;
                    st_nxt.bit_cnt = 7'h00;
                    st_nxt.write = cmd.write;
                    st_nxt.shift = {32'hFFFFFFFF, FRM_START, cmd.write ? OP_WRITE : OP_READ,
                                    cmd.target_device_number, cmd.reg_idx, TA_WRITE, cmd.wdata};  // [RQ12] [RQ10]
                end
            end
            M_RUN: begin
                if (st_r.phase == SMP_PHASE && !st_r.write && st_r.bit_cnt >= DATA_FIRST) begin
                    st_nxt.rdata = {st_r.rdata[14:0], st_r.din_s[1]};  // [RQ17]
                end
                if (st_r.phase == CHG_PHASE) begin             // [RQ16]
                    if (st_r.bit_cnt == FRAME_BITS) begin
                        st_nxt.oe = 1'h0;                      // [RQ15]
                        st_nxt.state = M_IDLE;
                        st_nxt.done = 1'h1;
                    end else begin
                        st_nxt.dout = st_r.shift[63];          // [RQ12] [RQ14]
                        st_nxt.shift = {st_r.shift[62:0], 1'h0};
                        st_nxt.oe = st_r.write || (st_r.bit_cnt < TA_FIRST_BIT);
                        st_nxt.bit_cnt = st_r.bit_cnt + 7'h01;
                    end
                end
            end
            default: st_nxt.state = M_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st_r <= '0;
            st_r.phase <= LAST_PHASE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pins = '{clk: st_r.mdc, dout: st_r.dout, oe: st_r.oe};
    assign rsp  = '{done: st_r.done, rdata: st_r.rdata};

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    chk_mdc_duty_cycle: assert property ($rose(st_r.mdc) |-> st_r.mdc [*4] ##1 !st_r.mdc [*4]) // [RQ11]
        else $error("management clock duty cycle wrong");
    chk_data_change_phase: assert property (($changed(st_r.dout) || $changed(st_r.oe)) // [RQ16]
        |-> $past(st_r.phase) == CHG_PHASE)
        else $error("data line changed off its phase");
    chk_idle_released: assert property (st_r.state == M_IDLE |-> !st_r.oe) // [RQ15]
        else $error("data line driven while idle");
    chk_read_sample_phase: assert property ($changed(st_r.rdata) |-> $past(st_r.phase) == SMP_PHASE) // [RQ17]
        else $error("read data sampled off its phase");
    chk_preamble_first: assert property ($rose(st_r.oe) |-> st_r.dout [*8]) // [RQ12]
        else $error("frame does not open with preamble ones");
    chk_read_ta_release: assert property (st_r.state == M_RUN && !st_r.write && st_r.bit_cnt > TA_FIRST_BIT // [RQ13]
        |-> !st_r.oe)
        else $error("master drives line during read turnaround");
    chk_frame_length: assert property (cmd.start && st_r.state == M_IDLE |-> ##[512:530] st_r.done) // [RQ22]
        else $error("frame did not complete in time");

    cov_read_frame: cover property (st_r.done && !st_r.write);
    cov_write_frame: cover property (st_r.done && st_r.write);
endmodule
`default_nettype wire

//--- mii_mgmt_slave_and_phy_master.sv
// management block: serial slave on the host pins plus the phy management master
// assumes slave_enable and device_ready come from logic on ref_clk
// Operation
// (RQ1) host polls byte test, then ready bit
// (RQ2) disable mid-pair leaves no half pending
// (RQ3) host write frame: preamble through data
// (RQ4) slave never drives line during writes
// (RQ5) host writes both words back to back
// (RQ6) second write half merged without checking
// (RQ7) host avoids writes to unused addresses
// (RQ8) slave output changes shortly after clock rise
// (RQ9) slave samples data on clock rise
// (RQ10) master serialises commands to the phys
// (RQ11) master clock 2.5 MHz, even, free-running
// (RQ12) master frame: preamble, start, op, addresses
// (RQ13) phy drives read turnaround zero, data
// (RQ14) master write turnaround one then zero
// (RQ15) master releases data line when idle
// (RQ16) master data changes 120 ns after rise; code changes it 100 ns (2 system clocks) after rise
// (RQ17) master samples 40 ns before rise; code samples the line on the same system clock edge that raises the clock
// (RQ18) software loads data before access write
// (RQ19) read result lands in data register
// (RQ20) data read selects phy or software value
// (RQ21) loader may only write the registers
// (RQ22) access write sets busy, completion clears
// (RQ23) access register field layout
// (RQ24) master clock divided from system clock
`timescale 1ns/1ns
`default_nettype none
module mii_mgmt_slave_and_phy_master import mii_mgmt_pkg::*; (
    input  wire logic          ref_clk,
    input  wire logic          rstn,
    input  wire logic          host_mdc,
    input  wire logic          host_mdio_in,
    output logic               host_mdio_out,
    output logic               host_mdio_oe,
    input  wire logic          slave_enable,
    input  wire logic          device_ready,
    input  wire loader_wr_type loader_wr,
    input  wire logic          port0_mgmt_data_pin_in,
    output logic               port0_mgmt_clock_pin,
    output logic               port0_mgmt_data_pin_out,
    output logic               port0_mgmt_data_pin_oe
);
    typedef enum logic [2:0] {S_PRE, S_START, S_HDR, S_RD, S_WR} slv_state_type;

    typedef struct packed {
        slv_state_type state;
        logic [5:0]    cnt;
        logic [11:0]   hdr;
        logic [15:0]   sh;
        logic          oe;
        logic          dout;
        logic [2:0]    mdc_s;
        logic [1:0]    dio_s;
        logic          rd_pend;
        logic          rd_hi;
        logic [31:0]   rd_latch;
        logic          wr_pend;
        logic          wr_hi;
        logic [15:0]   wr_half;
        logic [15:0]   sw_data;
        logic [15:0]   phy_rd;
        logic [4:0]    target_device_number;
        logic [4:0]    reg_idx;
        logic          wsel;
        logic          busy;
        logic          start;
    } top_st_type;

    top_st_type    st_r;
    top_st_type    st_nxt;
    phy_rsp_type   rsp;
    mgmt_pins_type pins;
    phy_cmd_type   cmd;
    logic          mdc_rise;
    logic          bit_in;
    logic          wr_go;
    logic [9:0]    wr_addr;
    logic [31:0]   wr_data;

    function automatic logic [31:0] rd_mux(input top_st_type s, input logic [9:0] a, input logic rdy);
        logic [31:0] v;
        v = 32'h00000000;
        case (a)
            OFS_PHY_DATA:   v = {16'h0000, s.wsel ? s.sw_data : s.phy_rd};  // [RQ20]
            OFS_PHY_ACCESS: begin
                v[ACC_PHY_LSB +: 5] = s.target_device_number;                            // [RQ23]
                v[ACC_IDX_LSB +: 5] = s.reg_idx;
                v[ACC_WSEL_BIT]     = s.wsel;
                v[ACC_BUSY_BIT]     = s.busy;
            end
            OFS_BYTE_TEST:  v = BYTE_TEST_PATTERN;
            OFS_HARDWARE_CONFIG_REG:     v[HWCFG_READY_BIT] = rdy;
            default:        v = 32'h00000000;
        endcase
        return v;
    endfunction

    function automatic logic is_single_word(input logic [9:0] a);
        return (a == OFS_BYTE_TEST) || (a == OFS_HARDWARE_CONFIG_REG) || (a == OFS_POWER_MGMT_CONTROL_REG) || (a == OFS_RESET_CONTROL_REG);
    endfunction

    assign mdc_rise = st_r.mdc_s[1] && !st_r.mdc_s[2];
    assign bit_in   = st_r.dio_s[1];

    always_comb begin
        logic [11:0] hn;
        logic [9:0]  ra;
        logic [31:0] fresh;
        hn = {st_r.hdr[10:0], bit_in};
        ra = {hn[8:5], hn[4:1], 2'h0};
        fresh = rd_mux(st_r, ra, device_ready);
        st_nxt = st_r;
        st_nxt.mdc_s = {st_r.mdc_s[1:0], host_mdc};
        st_nxt.dio_s = {st_r.dio_s[0], host_mdio_in};
        st_nxt.start = 1'h0;
        wr_go = 1'h0;
        wr_addr = 10'h000;
        wr_data = 32'h00000000;
        if (!slave_enable) begin
            st_nxt.state = S_PRE;                                // [RQ2]
            st_nxt.cnt = 6'h00;
            st_nxt.oe = 1'h0;
            st_nxt.rd_pend = 1'h0;
            st_nxt.wr_pend = 1'h0;
        end else if (mdc_rise) begin                             // [RQ9] [RQ8]
            case (st_r.state)
                S_PRE: begin
                    if (bit_in) begin
                        st_nxt.cnt = (st_r.cnt == PREAMBLE_LEN) ? st_r.cnt : st_r.cnt + 6'h01;
                    end else begin
                        st_nxt.state = (st_r.cnt == PREAMBLE_LEN) ? S_START : S_PRE;
                        st_nxt.cnt = 6'h00;
                    end
                end
                S_START: begin
                    st_nxt.state = bit_in ? S_HDR : S_PRE;
                    st_nxt.cnt = 6'h00;
                end
                S_HDR: begin
                    st_nxt.hdr = hn;
                    st_nxt.cnt = st_r.cnt + 6'h01;
                    if (st_r.cnt == HDR_BITS - 6'h01) begin
                        st_nxt.cnt = 6'h00;
                        st_nxt.state = S_PRE;
                        if (hn[9] && hn[11:10] == OP_READ) begin
                            st_nxt.state = S_RD;
                            if (is_single_word(ra)) begin
                                st_nxt.sh = hn[0] ? fresh[31:16] : fresh[15:0];  // [RQ2]
                            end else if (st_r.rd_pend && st_r.rd_hi != hn[0]) begin
                                st_nxt.sh = hn[0] ? st_r.rd_latch[31:16] : st_r.rd_latch[15:0];
                                st_nxt.rd_pend = 1'h0;
                            end else begin
                                st_nxt.rd_latch = fresh;
                                st_nxt.sh = hn[0] ? fresh[31:16] : fresh[15:0];
                                st_nxt.rd_pend = 1'h1;
                                st_nxt.rd_hi = hn[0];
                            end
                        end else if (hn[9] && hn[11:10] == OP_WRITE) begin
                            st_nxt.state = S_WR;
                        end
                    end
                end
                S_RD: begin
                    st_nxt.cnt = st_r.cnt + 6'h01;
                    if (st_r.cnt == 6'h00) begin
                        st_nxt.oe = 1'h1;
                        st_nxt.dout = 1'h0;
                    end else if (st_r.cnt <= 6'h10) begin
                        st_nxt.dout = st_r.sh[15];
                        st_nxt.sh = {st_r.sh[14:0], 1'h0};
                    end else begin
                        st_nxt.oe = 1'h0;
                        st_nxt.state = S_PRE;
                        st_nxt.cnt = 6'h00;
                    end
                end
                S_WR: begin
                    st_nxt.oe = 1'h0;                            // [RQ4]
                    st_nxt.cnt = st_r.cnt + 6'h01;
                    if (st_r.cnt >= 6'h02) begin
                        st_nxt.sh = {st_r.sh[14:0], bit_in};
                    end
                    if (st_r.cnt == 6'h11) begin
                        st_nxt.state = S_PRE;
                        st_nxt.cnt = 6'h00;
                        if (!st_r.wr_pend) begin
                            st_nxt.wr_pend = 1'h1;
                            st_nxt.wr_hi = st_r.hdr[0];
                            st_nxt.wr_half = {st_r.sh[14:0], bit_in};
                        end else begin
                            st_nxt.wr_pend = 1'h0;               // [RQ6]
                            wr_go = 1'h1;
                            wr_addr = {st_r.hdr[8:5], st_r.hdr[4:1], 2'h0};
                            wr_data = st_r.wr_hi ? {st_r.wr_half, st_r.sh[14:0], bit_in}
                                                 : {st_r.sh[14:0], bit_in, st_r.wr_half};
                        end
                    end
                end
                default: st_nxt.state = S_PRE;
            endcase
        end
        if (!wr_go && loader_wr.valid) begin                     // [RQ21]
            wr_go = 1'h1;
            wr_addr = loader_wr.addr;
            wr_data = loader_wr.data;
        end
        if (wr_go && !st_r.busy) begin
            if (wr_addr == OFS_PHY_DATA) begin
                st_nxt.sw_data = wr_data[15:0];
            end
            if (wr_addr == OFS_PHY_ACCESS) begin
                st_nxt.target_device_number = wr_data[ACC_PHY_LSB +: 5];     // [RQ23]
                st_nxt.reg_idx = wr_data[ACC_IDX_LSB +: 5];
                st_nxt.wsel = wr_data[ACC_WSEL_BIT];
                st_nxt.busy = 1'h1;                              // [RQ22]
                st_nxt.start = 1'h1;
            end
        end
        if (rsp.done) begin
            st_nxt.busy = 1'h0;                                  // [RQ22]
            if (!st_r.wsel) begin
                st_nxt.phy_rd = rsp.rdata;                       // [RQ19]
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st_r <= '0;
            st_r.sw_data <= PHY_DATA_RST;
            st_r.phy_rd <= PHY_DATA_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign cmd = '{start: st_r.start, write: st_r.wsel, target_device_number: st_r.target_device_number,
                   reg_idx: st_r.reg_idx, wdata: st_r.sw_data};   // [RQ10]

    phy_mgmt_master i_phy_mgmt_master (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .cmd     (cmd),
        .mdio_in (port0_mgmt_data_pin_in),
        .rsp     (rsp),
        .pins    (pins)
    );

    assign host_mdio_out           = st_r.dout;
    assign host_mdio_oe            = st_r.oe;
    assign port0_mgmt_clock_pin    = pins.clk;
    assign port0_mgmt_data_pin_out = pins.dout;
    assign port0_mgmt_data_pin_oe  = pins.oe;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    chk_write_no_drive: assert property (st_r.state inside {S_PRE, S_START, S_HDR, S_WR} |-> !st_r.oe) // [RQ4]
        else $error("slave drives line outside read data");
    chk_out_after_edge: assert property (($changed(st_r.dout) || $changed(st_r.oe)) // [RQ8]
        |-> $past(mdc_rise) || !$past(slave_enable))
        else $error("slave output changed without clock rise");
    chk_capture_on_rise: assert property ($changed(st_r.hdr) |-> $past(mdc_rise)) // [RQ9]
        else $error("header bit captured off clock rise");
    chk_disable_clears: assert property (!slave_enable |=> st_r.state == S_PRE && !st_r.rd_pend // [RQ2]
        && !st_r.wr_pend && !st_r.oe)
        else $error("slave left waiting for second half");
    chk_access_sets_busy: assert property (wr_go && wr_addr == OFS_PHY_ACCESS && !st_r.busy // [RQ22]
        |=> st_r.busy && st_r.start ##1 !st_r.start)
        else $error("access write did not start the master");
    chk_read_result: assert property (rsp.done && !st_r.wsel // [RQ19]
        |=> !st_r.busy && st_r.phy_rd == $past(rsp.rdata))
        else $error("phy read result not stored");
    chk_data_select: assert property (!st_r.wsel // [RQ20]
        |-> rd_mux(st_r, OFS_PHY_DATA, device_ready) == {16'h0000, st_r.phy_rd})
        else $error("data register read source wrong");
    chk_busy_holds_regs: assert property (st_r.busy |=> $stable(st_r.sw_data) && $stable(st_r.target_device_number) // [RQ22]
        && $stable(st_r.reg_idx) && $stable(st_r.wsel))
        else $error("management register changed while busy");
    chk_single_word_read: assert property (st_r.state == S_HDR && st_nxt.state == S_RD // [RQ2]
        && is_single_word({st_nxt.hdr[8:5], st_nxt.hdr[4:1], 2'h0}) |=> $stable(st_r.rd_pend))
        else $error("single word read disturbed pairing");
    chk_loader_data_write: assert property (loader_wr.valid && loader_wr.addr == OFS_PHY_DATA // [RQ21]
        && !st_r.busy && st_r.state != S_WR |=> st_r.sw_data == $past(loader_wr.data[15:0]))
        else $error("loader data write lost");

    cov_slave_read: cover property (st_r.state == S_RD && st_nxt.state == S_PRE);
    cov_slave_write_pair: cover property (wr_go && !loader_wr.valid);
    cov_loader_access: cover property (loader_wr.valid && loader_wr.addr == OFS_PHY_ACCESS);
endmodule
`default_nettype wire

//--- mgmt_phy_model.sv
// behavioural phy on the generated management link
// assumes the data line is pulled high when nobody drives it
`timescale 1ns/1ns
`default_nettype none
module mgmt_phy_model (
    input  wire logic        mdc,
    input  wire logic        line,
    input  wire logic [15:0] rd_val,
    output logic             oe,
    output logic             d,
    output logic [11:0]      hdr,
    output logic [17:0]      got
);
    int ones = 0;
    int n    = -1;
    initial begin
        oe = 1'b0;
        d = 1'b1;
        got = '0;
    end
    // sample on clock rise, answer just after it
    always @(posedge mdc) begin
        if (n < 0) begin
            if (line === 1'b1) ones = ones + 1;
            else begin
                if (ones >= 32) n = 0;
                ones = 0;
            end
        end else begin
            n = n + 1;
            if (n == 1 && line !== 1'b1) n = -1;
            if (n >= 2 && n <= 13) hdr = {hdr[10:0], line};
            if (n >= 14 && hdr[11:10] == 2'b01) got = {got[16:0], line};
            if (n == 14 && hdr[11:10] == 2'b10) begin
                oe <= #10 1'b1;
                d <= #10 1'b0;
            end
            if (n >= 15 && n <= 30 && hdr[11:10] == 2'b10) d <= #10 rd_val[30-n];
            if (n == 31) begin
                oe <= #10 1'b0;
                n = -1;
            end
        end
    end
endmodule
`default_nettype wire

//--- mii_mgmt_slave_and_phy_master_bench.sv
// bench: host serial link, loader writes and a phy model on port 0
// assumes the package constants; host link clock runs only within frames
`timescale 1ns/1ns
`default_nettype none
module mii_mgmt_slave_and_phy_master_bench import mii_mgmt_pkg::*;;
    logic          ref_clk = 1'b0;
    logic          rstn = 1'b0;
    logic          mdc = 1'b0;
    logic          hd = 1'b1;
    logic          hoe = 1'b0;
    logic          en = 1'b1;
    logic          rdy = 1'b0;
    loader_wr_type ld = '0;
    logic          h_out, h_oe, p_clk, p_out, p_oe, m_oe, m_d;
    logic [15:0]   m_rd = 16'h0000;
    logic [17:0]   m_got;
    logic [11:0]   m_hdr;
    int            n_errors = 0;
    int            n_tests = 0;
    // pull-ups on both data lines
    wire logic     h_line = hoe ? hd : (h_oe ? h_out : 1'b1);
    wire logic     p_line = p_oe ? p_out : (m_oe ? m_d : 1'b1);
    always #25 ref_clk = ~ref_clk;
    mii_mgmt_slave_and_phy_master i_mii_mgmt_slave_and_phy_master (
        .ref_clk(ref_clk), .rstn(rstn), .host_mdc(mdc), .host_mdio_in(h_line),
        .host_mdio_out(h_out), .host_mdio_oe(h_oe), .slave_enable(en), .device_ready(rdy),
        .loader_wr(ld), .port0_mgmt_data_pin_in(p_line), .port0_mgmt_clock_pin(p_clk),
        .port0_mgmt_data_pin_out(p_out), .port0_mgmt_data_pin_oe(p_oe));
    mgmt_phy_model i_mgmt_phy_model (
        .mdc(p_clk), .line(p_line), .rd_val(m_rd), .oe(m_oe), .d(m_d), .hdr(m_hdr), .got(m_got));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // one host clock period; s is the line just before this rise
    task automatic hbit(input logic b, input logic drv, output logic s);
        @(negedge ref_clk);
        s = h_line;
        hoe = drv;
        hd = b;
        mdc = 1'b0;
        repeat (4) @(negedge ref_clk);
        mdc = 1'b1;
        repeat (3) @(negedge ref_clk);
    endtask
    task automatic frame(input logic wr, input logic [9:0] a, input logic hi, input logic [15:0] wd,
                         output logic [15:0] rd);
        logic [63:0] f;
        logic        s;
        logic        bad;
        f = {32'hFFFFFFFF, 2'b01, wr ? OP_WRITE : OP_READ, 1'b1, a[9:6], a[5:2], hi, 2'b10, wd};
        bad = 1'b0;
        for (int i = 63; i >= 0; i--) begin
            hbit(f[i], wr || i >= 18, s);
            if (i < 16) rd[i] = s;
            if (wr) bad = bad | h_oe;
        end
        if (wr) chk("slave oe in write", 32'h0, {31'h0, bad});
    endtask
    task automatic rd32(input logic [9:0] a, output logic [31:0] v);
        frame(1'b0, a, 1'b0, 16'h0000, v[15:0]);
        frame(1'b0, a, 1'b1, 16'h0000, v[31:16]);
    endtask
    // upper word first, mapped offsets only
    task automatic wr32(input logic [9:0] a, input logic [31:0] v);
        logic [15:0] x;
        frame(1'b1, a, 1'b1, v[31:16], x);
        frame(1'b1, a, 1'b0, v[15:0], x);
    endtask
    task automatic ldwr(input logic [9:0] a, input logic [31:0] v);
        @(negedge ref_clk);
        ld = '{1'b1, a, v};
        @(negedge ref_clk);
        ld.valid = 1'b0;
    endtask
    task automatic wait_idle;
        logic [31:0] v;
        for (int i = 0; i < 6; i++) begin
            rd32(OFS_PHY_ACCESS, v);
            if (v[ACC_BUSY_BIT] === 1'b0) return;
        end
        n_errors++;
        end_sim;
    endtask
    function automatic logic [31:0] acc(input logic [4:0] p, input logic [4:0] r, input logic w);
        return {16'h0000, p, r, 4'h0, w, 1'b0};
    endfunction
    initial begin
        logic [31:0] v;
        logic [31:0] k;
        logic        pp;
        logic        bad;
        repeat (4) @(negedge ref_clk);
        rstn = 1'b1;
        rd32(OFS_BYTE_TEST, v);
        chk("byte test", BYTE_TEST_PATTERN, v);
        rd32(OFS_HARDWARE_CONFIG_REG, v);
        chk("ready bit low", 32'h0, {31'h0, v[HWCFG_READY_BIT]});
        rdy = 1'b1;
        rd32(OFS_HARDWARE_CONFIG_REG, v);
        chk("ready bit", 32'h1, {31'h0, v[HWCFG_READY_BIT]});
        rd32(OFS_PHY_DATA, v);
        chk("data reset", {16'h0000, PHY_DATA_RST}, v);
        rd32(OFS_PHY_ACCESS, v);
        chk("access reset", 32'h0, v);
        $display("test reset done");
        wr32(OFS_PHY_DATA, 32'h0000A5C3);
        wr32(OFS_PHY_ACCESS, acc(5'h13, 5'h0B, 1'b1));
        rd32(OFS_PHY_ACCESS, v);
        chk("access busy", acc(5'h13, 5'h0B, 1'b1) | 32'h1, v);
        wait_idle;
        chk("write header", {2'b01, 5'h13, 5'h0B}, m_hdr);
        chk("write ta data", {2'b10, 16'hA5C3}, m_got);
        rd32(OFS_PHY_DATA, v);
        chk("data soft", 32'h0000A5C3, v);
        $display("test phy write done");
        m_rd = 16'h3C5A;
        wr32(OFS_PHY_ACCESS, acc(5'h02, 5'h1F, 1'b0));
        wait_idle;
        chk("read header", {2'b10, 5'h02, 5'h1F}, m_hdr);
        rd32(OFS_PHY_DATA, v);
        chk("data phy", 32'h00003C5A, v);
        $display("test phy read done");
        frame(1'b0, OFS_PHY_DATA, 1'b1, 16'h0000, v[15:0]);
        en = 1'b0;
        repeat (4) @(negedge ref_clk);
        en = 1'b1;
        ldwr(OFS_PHY_DATA, 32'h00000F0F);
        ldwr(OFS_PHY_ACCESS, acc(5'h1F, 5'h00, 1'b1));
        ldwr(OFS_PHY_DATA, 32'h00001234);
        rd32(OFS_PHY_DATA, v);
        chk("pair after disable", 32'h00000F0F, v);
        wait_idle;
        chk("loader write", {2'b10, 16'h0F0F}, m_got);
        $display("test loader done");
        k = 0;
        bad = 1'b0;
        pp = p_clk;
        for (int i = 0; i < 80; i++) begin
            @(negedge ref_clk);
            if (p_clk && !pp) k = k + 1;
            pp = p_clk;
            bad = bad | p_oe;
        end
        chk("idle clock rises", 32'd10, k);
        chk("idle release", 32'h0, {31'h0, bad});
        $display("test idle done");
        end_sim;
    end
endmodule
`default_nettype wire
